// ===== rtl/ssbc_regs.vh
// Register map, field positions, reset values and timing counts of the shared bus control block.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef SSBC_REGS_VH
`define SSBC_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSBC_CFG_OFS 12'h000
`define SSBC_CMD_OFS 12'h004
`define SSBC_STAT_OFS 12'h008
`define SSBC_HELD_OFS 12'h00c
`define SSBC_FRAME_OFS 12'h010
// ----------------------------------------
// Config fields
// ----------------------------------------
`define SSBC_CFG_SLOTTED 0
`define SSBC_CFG_ADDRESSED 1
`define SSBC_CFG_SH_DIS 2
`define SSBC_CFG_ZERO_SAMPLE 3
`define SSBC_CFG_ST_ALLOW 4
`define SSBC_CFG_ST_ADR 5
`define SSBC_CFG_IDLE_SYNC 6
`define SSBC_CFG_POR_OFFLINE 7
`define SSBC_CFG_SCN_LSB 8
`define SSBC_CFG_DMODE_LSB 12
`define SSBC_CFG_ID_LSB 16
`define SSBC_CFG_MAXS_LSB 20
`define SSBC_CFG_RESET 32'h0000_0080
// ----------------------------------------
// Command bits (write one to act)
// ----------------------------------------
`define SSBC_CMD_ST_DONE 0
`define SSBC_CMD_ST_FAIL 1
`define SSBC_CMD_IF_DIS 2
// ----------------------------------------
// Bus states
// ----------------------------------------
`define SSBC_ST_OFFLINE 2'h0
`define SSBC_ST_SYNC 2'h1
`define SSBC_ST_ONLINE 2'h2
// ----------------------------------------
// Timing in ticks
// ----------------------------------------
`define SSBC_IDLE_TICKS 10'd510
`define SSBC_FLUSH_TICKS 10'd4
`define SSBC_PAUSE_MIN 10'd12
`define SSBC_PAUSE_MAX 10'd768
`endif

// ===== rtl/ssbc_tick_cnt.v
// Saturating tick counter with clear.
// Assumes tick_en is a one-cycle pulse per protocol tick.
`timescale 1ns/1ps
`default_nettype none
module ssbc_tick_cnt #(
   parameter W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire clr,
   input wire tick_en,
   output reg [W-1:0] cnt_q
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= {W{1'b0}};
      end else if (clr) begin
         cnt_q <= {W{1'b0}};
      end else if (tick_en && (cnt_q != {W{1'b1}})) begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // ssbc_tick_cnt
`default_nettype wire

// ===== rtl/ssbc_top.v
// Shared single-wire bus control: sampling, bus state, self-test start, status fields.
// Assumes a line decoder supplies one-cycle pulse events and a measurement source.
// How it works
// - Capture measurement at function pulse rising edge and keep it for later output.
// - Broadcast sample pulse captures in every device not offline unless hold-disable is set.
// - Slotted output pulse for slot zero captures when zero-sample option is set.
// - Held data goes out on next addressed frame; repeats return same value.
// - Self-test or interface disable discards the held data.
// - Poll without held data transmits the current measurement instead.
// - Offline never drives the bus; offline at reset, self-test, contention.
// - Leave offline only when functional, pipelines flushed and bus high.
// - Addressed mode goes straight from offline to online.
// - Slotted bus-sync ignores addressing pulses but acts on broadcasts.
// - Sync pulse sets counter so next addressing pulse targets ID zero.
// - Idle-sync resets counter and goes online after more than 510 high ticks.
// - Power-up-offline zero puts slotted device online synchronized after reset.
// - Online drops offline on reset, self-test request, or slotted contention.
// - Broadcast diagnostics start at once; addressed diagnostics only when addressed.
// - No frame is sent in reply to a diagnostic pulse.
// - Contention during own frame with diagnostics allowed, neither slotted nor addressed, releases bus, starts test.
// - Test failure sets hard error; serial bit 17 for formats 1, 5, 7.
// - Test error in added bits per format 2 and 6, ID nibble bit 2.
// - Status nibble: error status bits 1:0 in formats 0 to 2, combined error bit 0 in format 3, serial protocol bits 3:2 in formats 1, 5, 7.
// - Pause pulse after 12 ticks, then every 768 ticks as the counter wraps to zero after reaching 767.
// - Slot counter counts addressing pulses only, wraps to zero past sensor count.
`timescale 1ns/1ps
`default_nettype none
`include "ssbc_regs.vh"
module ssbc_top #(
   parameter MW = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire tick,
   input wire logic_ready,
   input wire line_in,
   input wire pulse_sample,
   input wire pulse_output,
   input wire pulse_diag,
   input wire pulse_sync,
   input wire pulse_addressed,
   input wire contention,
   input wire frame_active,
   input wire frame_end,
   input wire serial_sync_bit,
   input wire serial_data_bit,
   input wire soft_error,
   input wire [MW-1:0] meas_data,
   input wire pause_tick,
   output reg frame_start_q,
   output reg [MW-1:0] frame_data_q,
   output reg [3:0] status_nibble_q,
   output reg selftest_start_q,
   output reg selftest_bit_q,
   output reg pause_done_q,
   output wire line_oe_n,
   output wire [1:0] bus_state
);
   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   reg [31:0] cfg_q;
   reg st_fail_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg held_vld_q;
   reg [MW-1:0] held_q;
   reg [3:0] slot_q;
   reg [1:0] frame_cnt_q;
   reg st_run_q;
   reg [9:0] pause_q;
   reg por_pend_q;
   wire wr_en;
   wire cmd_wr;
   wire st_done;
   wire if_dis;
   wire slotted;
   wire addressed;
   wire [2:0] scn;
   wire [2:0] dmode;
   wire [3:0] my_id;
   wire [3:0] max_s;
   wire [9:0] idle_cnt;
   wire [9:0] flush_cnt;
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign pslverr = psel && penable && !((paddr == `SSBC_CFG_OFS) ||
      (paddr == `SSBC_CMD_OFS) || (paddr == `SSBC_STAT_OFS) ||
      (paddr == `SSBC_HELD_OFS) || (paddr == `SSBC_FRAME_OFS));
   assign cmd_wr = wr_en && (paddr == `SSBC_CMD_OFS);
   assign st_done = cmd_wr && pwdata[`SSBC_CMD_ST_DONE];
   assign if_dis = cmd_wr && pwdata[`SSBC_CMD_IF_DIS];
   assign slotted = cfg_q[`SSBC_CFG_SLOTTED];
   assign addressed = cfg_q[`SSBC_CFG_ADDRESSED];
   assign scn = cfg_q[`SSBC_CFG_SCN_LSB +: 3];
   assign dmode = cfg_q[`SSBC_CFG_DMODE_LSB +: 3];
   assign my_id = cfg_q[`SSBC_CFG_ID_LSB +: 4];
   assign max_s = cfg_q[`SSBC_CFG_MAXS_LSB +: 4];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= `SSBC_CFG_RESET;
      end else if (wr_en && (paddr == `SSBC_CFG_OFS)) begin
         cfg_q <= pwdata;
      end
   end
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `SSBC_CFG_OFS: prdata = cfg_q;
         `SSBC_STAT_OFS: prdata = {20'h00000, slot_q, 2'h0, st_run_q, held_vld_q, st_fail_q,
            1'b0, state_q};
         `SSBC_HELD_OFS: prdata = {{(32-MW){1'b0}}, held_q};
         `SSBC_FRAME_OFS: prdata = {22'h0, pause_q};
         default: prdata = 32'h0000_0000;
      endcase
   end
   // ----------------------------------------
   // Tick counters
   // ----------------------------------------
   ssbc_tick_cnt #(.W(10)) u_idle (
      .pclk(pclk),
      .presetn(presetn),
      .clr(!line_in),
      .tick_en(tick),
      .cnt_q(idle_cnt)
   );
   ssbc_tick_cnt #(.W(10)) u_flush (
      .pclk(pclk),
      .presetn(presetn),
      .clr(!logic_ready || (state_q != `SSBC_ST_OFFLINE) || st_run_q),
      .tick_en(tick),
      .cnt_q(flush_cnt)
   );
   // ----------------------------------------
   // Self-test start and result
   // ----------------------------------------
   wire diag_hit;
   wire stomp_hit;
   wire st_req;
   wire my_slot;
   wire addr_ok;
   assign addr_ok = (state_q == `SSBC_ST_ONLINE);
   assign my_slot = addressed ? pulse_addressed : (slot_q == my_id);
   assign diag_hit = pulse_diag && cfg_q[`SSBC_CFG_ST_ALLOW] && (slotted || addressed) &&
      (state_q != `SSBC_ST_OFFLINE) &&
      (!cfg_q[`SSBC_CFG_ST_ADR] || (addr_ok && my_slot));
   assign stomp_hit = contention && frame_active && cfg_q[`SSBC_CFG_ST_ALLOW] &&
      !slotted && !addressed;
   assign st_req = diag_hit || stomp_hit;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_run_q <= 1'b0;
         st_fail_q <= 1'b0;
         selftest_start_q <= 1'b0;
      end else begin
         selftest_start_q <= st_req && !st_run_q;
         if (st_req) begin
            st_run_q <= 1'b1;
         end else if (st_done) begin
            st_run_q <= 1'b0;
         end
         if (st_done) begin
            st_fail_q <= pwdata[`SSBC_CMD_ST_FAIL];
         end
      end
   end
   // ----------------------------------------
   // Bus state machine
   // ----------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         `SSBC_ST_OFFLINE: begin
            if (logic_ready && !st_run_q && (flush_cnt >= `SSBC_FLUSH_TICKS) && line_in) begin
               if (addressed || !slotted) begin
                  state_d = `SSBC_ST_ONLINE;
               end else begin
                  state_d = `SSBC_ST_SYNC;
               end
            end
         end
         `SSBC_ST_SYNC: begin
            if (pulse_sync || (por_pend_q && !cfg_q[`SSBC_CFG_POR_OFFLINE])) begin
               state_d = `SSBC_ST_ONLINE;
            end else if (cfg_q[`SSBC_CFG_IDLE_SYNC] && (idle_cnt > `SSBC_IDLE_TICKS)) begin
               state_d = `SSBC_ST_ONLINE;
            end
         end
         `SSBC_ST_ONLINE: begin
            if (slotted && contention && !stomp_hit) begin
               state_d = `SSBC_ST_OFFLINE;
            end
         end
         default: state_d = `SSBC_ST_OFFLINE;
      endcase
      if (st_req || st_run_q || if_dis) begin
         state_d = `SSBC_ST_OFFLINE;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= `SSBC_ST_OFFLINE;
         por_pend_q <= 1'b1;
      end else begin
         state_q <= state_d;
         if (state_q != `SSBC_ST_OFFLINE) begin
            por_pend_q <= 1'b0;
         end
      end
   end
   assign bus_state = state_q;
   assign line_oe_n = !(frame_active && (state_q == `SSBC_ST_ONLINE));
   // ----------------------------------------
   // Slot counter
   // ----------------------------------------
   wire sync_idle;
   assign sync_idle = cfg_q[`SSBC_CFG_IDLE_SYNC] && (idle_cnt > `SSBC_IDLE_TICKS) &&
      (state_q == `SSBC_ST_SYNC);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_q <= 4'h0;
      end else if (pulse_sync || sync_idle || (state_q == `SSBC_ST_OFFLINE)) begin
         slot_q <= 4'h0;
      end else if (slotted && pulse_addressed && (state_q == `SSBC_ST_ONLINE)) begin
         slot_q <= (slot_q >= max_s) ? 4'h0 : slot_q + 4'h1;
      end
   end
   // ----------------------------------------
   // Sample and hold, frame data
   // ----------------------------------------
   wire cap_bcast;
   wire cap_zero;
   wire poll;
   assign cap_bcast = pulse_sample && !cfg_q[`SSBC_CFG_SH_DIS] &&
      (state_q != `SSBC_ST_OFFLINE);
   assign cap_zero = pulse_output && slotted && (slot_q == 4'h0) &&
      cfg_q[`SSBC_CFG_ZERO_SAMPLE] && (state_q == `SSBC_ST_ONLINE);
   assign poll = pulse_output && addr_ok && my_slot && (slotted || addressed);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_vld_q <= 1'b0;
         held_q <= {MW{1'b0}};
         frame_data_q <= {MW{1'b0}};
         frame_start_q <= 1'b0;
      end else begin
         frame_start_q <= poll;
         if (st_req || st_run_q || if_dis) begin
            held_vld_q <= 1'b0;
         end else if (cap_bcast || cap_zero) begin
            held_vld_q <= 1'b1;
            held_q <= meas_data;
         end
         if (poll) begin
            if (held_vld_q) begin
               frame_data_q <= held_q;
            end else begin
               frame_data_q <= meas_data;
            end
         end
      end
   end
   // ----------------------------------------
   // Status nibble and self-test bits
   // ----------------------------------------
   wire hard;
   assign hard = st_fail_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_nibble_q <= 4'h0;
         selftest_bit_q <= 1'b0;
         frame_cnt_q <= 2'h0;
      end else begin
         if (frame_end) begin
            frame_cnt_q <= frame_cnt_q + 2'h1;
         end
         case (scn)
            3'h0: status_nibble_q <= {2'h0, soft_error, hard};
            3'h1: status_nibble_q <= {serial_sync_bit, serial_data_bit, soft_error, hard};
            3'h2: status_nibble_q <= {my_id[1:0], soft_error, hard};
            3'h3: status_nibble_q <= {3'h0, soft_error | hard};
            3'h4: status_nibble_q <= {2'h0, my_id[1:0]};
            3'h5: status_nibble_q <= {serial_sync_bit, serial_data_bit, my_id[1:0]};
            3'h6: status_nibble_q <= {soft_error, hard, my_id[1:0]};
            3'h7: status_nibble_q <= {serial_sync_bit, serial_data_bit, 1'b0, soft_error | hard};
            default: status_nibble_q <= 4'h0;
         endcase
         // Self-test bit slot: serial bit 17, added status bits, or ID nibble bit 2
         if ((dmode == 3'h2) && frame_cnt_q[0]) begin
            selftest_bit_q <= st_fail_q;
         end else if ((dmode == 3'h6) && (frame_cnt_q == 2'h3)) begin
            selftest_bit_q <= st_fail_q;
         end else if (dmode[2]) begin
            selftest_bit_q <= st_fail_q;
         end else if ((scn == 3'h1) || (scn == 3'h5) || (scn == 3'h7)) begin
            selftest_bit_q <= st_fail_q;
         end else begin
            selftest_bit_q <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // Pause pulse
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_q <= 10'd0;
         pause_done_q <= 1'b0;
      end else begin
         pause_done_q <= 1'b0;
         if (frame_end) begin
            pause_q <= 10'd0;
         end else if (pause_tick) begin
            if (pause_q >= `SSBC_PAUSE_MAX - 10'd1) begin
               pause_q <= 10'd0;
            end else begin
               pause_q <= pause_q + 10'd1;
            end
            if (pause_q == `SSBC_PAUSE_MIN - 10'd1) begin
               pause_done_q <= 1'b1;
            end
         end
      end
   end
endmodule // ssbc_top
`default_nettype wire

// ===== testbench/ssbc_host_model.sv
// Host model: sends function pulses, runs frames and stomps them on request.
// Assumes an open-drain line with pull-up; the device pulls low via line_oe_n.
`timescale 1ns/1ps
`default_nettype none
module ssbc_host_model (
   input wire logic pclk,
   input wire logic frame_start_q,
   input wire logic plain_kick,
   input wire logic stomp_en,
   input wire logic line_oe_n,
   output logic [4:0] pulses,
   output logic contention,
   output logic frame_end,
   output wire logic frame_active,
   output wire logic line_in
);
   logic [3:0] frame_cnt;
   logic host_low;
   initial begin
      pulses = 5'h00;
      contention = 1'b0;
      frame_end = 1'b0;
      host_low = 1'b0;
      frame_cnt = 4'h0;
   end
   // Pull-up keeps the line high unless a party pulls it low
   assign line_in = !(host_low || !line_oe_n);
   assign frame_active = frame_cnt != 4'h0;
   task automatic send(input logic [4:0] kind);
      @(posedge pclk);
      host_low <= 1'b1;
      pulses <= kind;
      @(posedge pclk);
      host_low <= 1'b0;
      pulses <= 5'h00;
   endtask
   always @(posedge pclk) begin
      frame_end <= frame_cnt == 4'h1;
      contention <= stomp_en && frame_cnt == 4'h4;
      if (frame_start_q || plain_kick)
         frame_cnt <= 4'h8;
      else if (frame_cnt != 4'h0)
         frame_cnt <= frame_cnt - 4'h1;
   end
endmodule // ssbc_host_model
`default_nettype wire

// ===== testbench/ssbc_monitor.sv
// Assertions on the shared bus control ports.
// Assumes binding into ssbc_top; the config word is snooped from APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "ssbc_regs.vh"
module ssbc_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pulse_output,
   input wire logic pulse_diag,
   input wire logic pulse_sync,
   input wire logic pulse_addressed,
   input wire logic contention,
   input wire logic frame_active,
   input wire logic frame_start_q,
   input wire logic selftest_start_q,
   input wire logic line_oe_n,
   input wire logic [1:0] bus_state
);
   logic [31:0] cfg_q;
   wire logic plain;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cfg_q <= `SSBC_CFG_RESET;
      else if (psel && penable && pready && pwrite && paddr == `SSBC_CFG_OFS)
         cfg_q <= pwdata;
   end
   assign plain = !cfg_q[0] && !cfg_q[1];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_offline_quiet: assert property (bus_state == 2'h0 |-> line_oe_n)
      else $error("line driven offline");
   a_addr_direct: assert property ($past(bus_state) == 2'h0 && bus_state != 2'h0
      && cfg_q[1] && !cfg_q[0] |-> bus_state == 2'h2) else $error("sync in addressed");
   a_sync_online: assert property (cfg_q[0] && bus_state == 2'h1 && pulse_sync
      |=> bus_state == 2'h2) else $error("sync pulse ignored");
   a_diag_silent: assert property (pulse_diag && !pulse_output |=> !frame_start_q)
      else $error("frame after diag");
   a_bcast_diag: assert property (pulse_diag && bus_state != 2'h0 && cfg_q[4]
      && !cfg_q[5] && !plain |=> selftest_start_q) else $error("no broadcast test");
   a_diag_blocked: assert property ((pulse_diag || contention) && !cfg_q[4]
      |=> !selftest_start_q) else $error("test while disabled");
   a_stomp_test: assert property (contention && frame_active && cfg_q[4] && plain
      && bus_state == 2'h2 |=> selftest_start_q ##1 line_oe_n) else $error("stomp missed");
   a_test_offline: assert property (selftest_start_q |-> ##[0:1] bus_state == 2'h0)
      else $error("online in test");
   a_poll_frame: assert property (pulse_output && pulse_addressed && cfg_q[1]
      && !cfg_q[0] && bus_state == 2'h2 |=> frame_start_q) else $error("poll unanswered");
endmodule // ssbc_monitor
bind ssbc_top ssbc_monitor u_ssbc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pulse_output(pulse_output), .pulse_diag(pulse_diag), .pulse_sync(pulse_sync),
   .pulse_addressed(pulse_addressed), .contention(contention), .frame_active(frame_active),
   .frame_start_q(frame_start_q), .selftest_start_q(selftest_start_q),
   .line_oe_n(line_oe_n), .bus_state(bus_state));
`default_nettype wire

// ===== testbench/ssbc_top_tb.sv
// Bench of the shared bus control block: table of sampling cases, then hand tests.
// Assumes ssbc_top beside the host model; APB answers without wait states.
`timescale 1ns/1ps
`default_nettype none
`include "ssbc_regs.vh"
module ssbc_top_tb;
   typedef struct packed {
      logic [31:0] cfg;
      logic [4:0] kind;
      logic [15:0] meas;
      logic fs;
      logic [15:0] data;
   } ssbc_row_t;
   logic pclk, presetn, psel, penable, pwrite, logic_ready, plain_kick, stomp_en, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [15:0] meas;
   wire [31:0] prdata;
   wire [15:0] frame_data_q;
   wire [4:0] pulses;
   wire [3:0] status_nibble_q;
   wire [1:0] bus_state;
   wire pready, pslverr, frame_start_q, selftest_start_q, selftest_bit_q, pause_done_q;
   wire line_oe_n, contention, frame_active, frame_end, line_in;
   ssbc_row_t rows [0:5];
   int n_mismatch, checked, cyc;
   ssbc_top u_ssbc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tick(1'b1), .logic_ready(logic_ready), .line_in(line_in),
      .pulse_sample(pulses[0]), .pulse_output(pulses[1]), .pulse_diag(pulses[2]),
      .pulse_sync(pulses[3]), .pulse_addressed(pulses[4]), .contention(contention),
      .frame_active(frame_active), .frame_end(frame_end), .serial_sync_bit(1'b0),
      .serial_data_bit(1'b0), .soft_error(1'b0), .meas_data(meas), .pause_tick(1'b1),
      .frame_start_q(frame_start_q), .frame_data_q(frame_data_q),
      .status_nibble_q(status_nibble_q), .selftest_start_q(selftest_start_q),
      .selftest_bit_q(selftest_bit_q), .pause_done_q(pause_done_q), .line_oe_n(line_oe_n),
      .bus_state(bus_state));
   ssbc_host_model u_ssbc_host_model (.pclk(pclk), .frame_start_q(frame_start_q),
      .plain_kick(plain_kick), .stomp_en(stomp_en), .line_oe_n(line_oe_n), .pulses(pulses),
      .contention(contention), .frame_end(frame_end), .frame_active(frame_active),
      .line_in(line_in));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ev(input logic [4:0] k, input logic [15:0] m);
      @(posedge pclk);
      meas <= m;
      u_ssbc_host_model.send(k);
      #1;
   endtask
   task automatic poll(input logic [15:0] m, input logic [15:0] d);
      ev(5'h12, m);
      chk1(frame_start_q, 1'b1);
      chk({16'h0, frame_data_q}, {16'h0, d});
      repeat (10) @(posedge pclk);
   endtask
   task automatic wait_state(input logic [1:0] s);
      for (int n = 0; n < 2000 && bus_state !== s; n++)
         @(posedge pclk);
      chk({30'h0, bus_state}, {30'h0, s});
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, logic_ready, plain_kick, stomp_en, presetn} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      meas = 16'h0;
      rows = '{'{32'h12, 5'h01, 16'h1111, 1'b0, 16'h0}, '{32'h12, 5'h12, 16'h2222, 1'b1, 16'h1111},
         '{32'h12, 5'h02, 16'h3333, 1'b0, 16'h0}, '{32'h16, 5'h01, 16'h4444, 1'b0, 16'h0},
         '{32'h16, 5'h12, 16'h5555, 1'b1, 16'h1111}, '{32'h12, 5'h12, 16'h6666, 1'b1, 16'h1111}};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SSBC_CFG_OFS, 32'h0);
      chk(rd, `SSBC_CFG_RESET);
      apb(1'b0, `SSBC_STAT_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h014, 32'h0);
      chk1(err, 1'b1);
      repeat (20) @(posedge pclk);
      chk1(bus_state == 2'h0, 1'b1);
      $display("reset test done");
      apb(1'b1, `SSBC_CFG_OFS, 32'h12);
      logic_ready <= 1'b1;
      wait_state(2'h2);
      foreach (rows[i]) begin
         apb(1'b1, `SSBC_CFG_OFS, rows[i].cfg);
         ev(rows[i].kind, rows[i].meas);
         chk1(frame_start_q, rows[i].fs);
         if (rows[i].fs)
            chk({16'h0, frame_data_q}, {16'h0, rows[i].data});
         repeat (10) @(posedge pclk);
      end
      $display("table test done");
      ev(5'h01, 16'h9999);
      apb(1'b1, `SSBC_CMD_OFS, 32'h4);
      #1;
      chk1(bus_state == 2'h0, 1'b1);
      wait_state(2'h2);
      poll(16'haaaa, 16'haaaa);
      ev(5'h01, 16'hbbbb);
      ev(5'h04, 16'h0);
      chk1(selftest_start_q, 1'b1);
      chk1(frame_start_q, 1'b0);
      repeat (2) @(posedge pclk);
      chk1(bus_state == 2'h0, 1'b1);
      apb(1'b1, `SSBC_CMD_OFS, 32'h3);
      apb(1'b0, `SSBC_STAT_OFS, 32'h0);
      chk1(rd[3], 1'b1);
      wait_state(2'h2);
      poll(16'hcccc, 16'hcccc);
      chk1(status_nibble_q[0], 1'b1);
      apb(1'b1, `SSBC_CFG_OFS, 32'h112);
      repeat (2) @(posedge pclk);
      chk1(selftest_bit_q, 1'b1);
      chk({28'h0, status_nibble_q}, 32'h1);
      apb(1'b1, `SSBC_CFG_OFS, 32'h4012);
      repeat (2) @(posedge pclk);
      chk1(selftest_bit_q, 1'b1);
      apb(1'b1, `SSBC_CFG_OFS, 32'h32);
      ev(5'h04, 16'h0);
      chk1(selftest_start_q, 1'b0);
      ev(5'h14, 16'h0);
      chk1(selftest_start_q, 1'b1);
      apb(1'b1, `SSBC_CMD_OFS, 32'h1);
      wait_state(2'h2);
      $display("diagnostic test done");
      apb(1'b1, `SSBC_CFG_OFS, 32'h0031_0019);
      apb(1'b1, `SSBC_CMD_OFS, 32'h4);
      wait_state(2'h1);
      ev(5'h12, 16'h0);
      chk1(frame_start_q, 1'b0);
      ev(5'h08, 16'h0);
      chk1(bus_state == 2'h2, 1'b1);
      ev(5'h12, 16'hdddd);
      chk1(frame_start_q, 1'b0);
      poll(16'heeee, 16'hdddd);
      apb(1'b1, `SSBC_CFG_OFS, 32'h0031_0059);
      apb(1'b1, `SSBC_CMD_OFS, 32'h4);
      wait_state(2'h1);
      repeat (400) @(posedge pclk);
      chk1(bus_state == 2'h1, 1'b1);
      wait_state(2'h2);
      $display("slotted test done");
      apb(1'b1, `SSBC_CFG_OFS, 32'h10);
      apb(1'b1, `SSBC_CMD_OFS, 32'h4);
      wait_state(2'h2);
      stomp_en <= 1'b1;
      plain_kick <= 1'b1;
      @(posedge pclk);
      plain_kick <= 1'b0;
      for (int n = 0; n < 20 && selftest_start_q !== 1'b1; n++)
         @(posedge pclk);
      chk1(selftest_start_q, 1'b1);
      stomp_en <= 1'b0;
      @(posedge pclk);
      chk1(line_oe_n, 1'b1);
      for (int n = 0; n < 20 && frame_end !== 1'b1; n++)
         @(posedge pclk);
      repeat (`SSBC_PAUSE_MIN) @(posedge pclk);
      chk1(pause_done_q, 1'b0);
      @(posedge pclk);
      chk1(pause_done_q, 1'b1);
      repeat (`SSBC_PAUSE_MAX - 1) @(posedge pclk);
      chk1(pause_done_q, 1'b0);
      @(posedge pclk);
      chk1(pause_done_q, 1'b1);
      $display("pause test done");
      presetn <= 1'b0;
      logic_ready <= 1'b0;
      repeat (2) @(posedge pclk);
      chk1(bus_state == 2'h0, 1'b1);
      presetn <= 1'b1;
      apb(1'b0, `SSBC_CFG_OFS, 32'h0);
      chk(rd, `SSBC_CFG_RESET);
      apb(1'b1, `SSBC_CFG_OFS, 32'h19);
      logic_ready <= 1'b1;
      wait_state(2'h2);
      apb(1'b0, `SSBC_STAT_OFS, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, `SSBC_CFG_OFS, 32'h1);
      ev(5'h04, 16'h0);
      chk1(selftest_start_q, 1'b0);
      $display("stomp and reset test done");
      stop_test();
   end
endmodule // ssbc_top_tb
`default_nettype wire
